// ===== rtl/usr_desc_rom.sv
// Descriptor table read one byte at a time, fixed except for the class and protocol bytes, which follow the revision.
module usr_desc_rom #(
    parameter logic [15:0] VENDOR_CODE = 16'h1234,
    parameter logic [15:0] PRODUCT_CODE = 16'h5678,
    parameter logic [15:0] DEV_RELEASE = 16'h0200
) (
    input wire logic [6:0] i_addr,   // Byte address into the table
    input wire logic i_rev_late,     // Later silicon revision
    output logic [7:0] o_byte        // Table byte at i_addr
);
    // The vendor, product and release defaults are arbitrary values.
    localparam int N = usr_pkg::ROM_SIZE;
    localparam logic [8*N-1:0] TABLE = {
        8'h12, 8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08,
        VENDOR_CODE[7:0], VENDOR_CODE[15:8],
        PRODUCT_CODE[7:0], PRODUCT_CODE[15:8],
        DEV_RELEASE[7:0], DEV_RELEASE[15:8],
        8'h01, 8'h02, 8'h03, 8'h01,
        8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, 8'hA0,
        8'h50, 8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h07, 8'h05, 8'h81, 8'h02, 8'h40, 8'h00,
        8'h00, 8'h07, 8'h05, 8'h02, 8'h02, 8'h40, 8'h00, 8'h00,
        8'h07, 8'h05, 8'h83, 8'h03, 8'h08, 8'h00, 8'h01,
        8'h04, 8'h03, 8'h04, 8'h09,
        8'h10, 8'h03, 8'h41, 8'h00, 8'h43, 8'h00, 8'h4D, 8'h00,
        8'h45, 8'h00, 8'h4E, 8'h00, 8'h45, 8'h00, 8'h54, 8'h00,
        8'h1E, 8'h03, 8'h55, 8'h00, 8'h53, 8'h00, 8'h42, 8'h00,
        8'h20, 8'h00, 8'h31, 8'h00, 8'h30, 8'h00, 8'h2F, 8'h00,
        8'h31, 8'h00, 8'h30, 8'h00, 8'h30, 8'h00, 8'h20, 8'h00,
        8'h4C, 8'h00, 8'h41, 8'h00, 8'h4E, 8'h00,
        8'h0A, 8'h03, 8'h30, 8'h00, 8'h30, 8'h00, 8'h30, 8'h00,
        8'h31, 8'h00
    };
    wire in_range = int'(i_addr) < N;
    wire [6:0] rev_addr = 7'(N - 1) - i_addr;
    wire [7:0] raw = in_range ? TABLE[rev_addr*8 +: 8] : 8'h00;
    wire rev_byte = i_addr == usr_pkg::ROM_ITF_CLASS ||
                    i_addr == usr_pkg::ROM_ITF_PROTO;
    wire [7:0] class_code = i_rev_late ? usr_pkg::CLASS_LATE
                                       : usr_pkg::CLASS_EARLY;
    assign o_byte = rev_byte ? class_code : raw;
endmodule

// ===== rtl/usr_dev_end.sv
// Device end: decodes SETUP packets and answers standard requests.
module usr_dev_end (
    input wire logic i_sys_clk,         // System clock, 25 MHz
    input wire logic i_rst_b,           // Asynchronous reset, active low
    usr_ep0_if.dev ep,                  // Endpoint-zero link
    input wire logic i_rev_late,        // Later silicon revision
    input wire logic [3:0] i_ep_halt,   // Halt of EP 00, 81, 02, 83
    input wire logic i_self_powered,    // Device status bit 0
    input wire logic i_remote_wake_en,  // Device status bit 1
    output logic o_configured,          // Configuration 1 selected
    output logic [7:0] o_config_value   // Current configuration value
);
    // Fields of the SETUP packet, first byte in the low bits.
    wire [7:0] bm_req = ep.setup_pkt[7:0];
    wire [7:0] req = ep.setup_pkt[15:8];
    wire [7:0] val_l = ep.setup_pkt[23:16];
    wire [7:0] val_h = ep.setup_pkt[31:24];
    wire [7:0] idx_l = ep.setup_pkt[39:32];
    wire [15:0] idx = ep.setup_pkt[47:32];
    wire [15:0] w_len = ep.setup_pkt[63:48];

    // Number of bytes to send: the shorter of the two lengths.
    function automatic logic [15:0] clip(input logic [15:0] full,
                                         input logic [15:0] asked);
        clip = (asked < full) ? asked : full;
    endfunction

    // Halt bit for an endpoint address, zero when not one of ours.
    function automatic logic halt_of(input logic [7:0] addr,
                                     input logic [3:0] halt);
        unique case (addr)
            usr_pkg::EP_CTRL: halt_of = halt[0];
            usr_pkg::EP_BULK_IN: halt_of = halt[1];
            usr_pkg::EP_BULK_OUT: halt_of = halt[2];
            usr_pkg::EP_INT_IN: halt_of = halt[3];
            default: halt_of = 1'b0;
        endcase
    endfunction

    // Request decode.
    wire is_set_cfg = bm_req == usr_pkg::BM_OUT_DEV &&
                      req == usr_pkg::RQ_SET_CONFIG;
    wire set_cfg_ok = is_set_cfg && val_h == 8'h00 &&
                      (val_l == usr_pkg::CFG_NONE ||
                       val_l == usr_pkg::CFG_ONE);
    wire is_get_desc = bm_req == usr_pkg::BM_IN_DEV &&
                       req == usr_pkg::RQ_GET_DESC;
    wire lang_ok = idx == usr_pkg::LANG_ID;
    wire is_str = is_get_desc && val_h == usr_pkg::DT_STRING;
    wire desc_dev = is_get_desc && val_h == usr_pkg::DT_DEVICE;
    wire desc_cfg = is_get_desc && val_h == usr_pkg::DT_CONFIG;
    wire desc_s0 = is_str && val_l == 8'h00;
    wire desc_s1 = is_str && val_l == 8'h01 && lang_ok;
    wire desc_s2 = is_str && val_l == 8'h02 && lang_ok;
    wire desc_s3 = is_str && val_l == 8'h03 && lang_ok;
    wire any_desc = desc_dev | desc_cfg | desc_s0 | desc_s1 |
                    desc_s2 | desc_s3;
    wire get_cfg = bm_req == usr_pkg::BM_IN_DEV &&
                   req == usr_pkg::RQ_GET_CONFIG;
    wire st_dev = bm_req == usr_pkg::BM_IN_DEV &&
                  req == usr_pkg::RQ_GET_STATUS;
    wire st_itf = bm_req == usr_pkg::BM_IN_ITF &&
                  req == usr_pkg::RQ_GET_STATUS && idx_l == 8'h00;
    wire ep_known = idx_l == usr_pkg::EP_CTRL ||
                    idx_l == usr_pkg::EP_BULK_IN ||
                    idx_l == usr_pkg::EP_BULK_OUT ||
                    idx_l == usr_pkg::EP_INT_IN;
    wire st_ep = bm_req == usr_pkg::BM_IN_EP &&
                 req == usr_pkg::RQ_GET_STATUS && ep_known;
    wire any_reg = get_cfg | st_dev | st_itf | st_ep;
    wire supported = set_cfg_ok | any_desc | any_reg;

    // Table entry chosen by the descriptor request.
    wire [6:0] desc_base =
        desc_dev ? usr_pkg::ROM_DEV :
        desc_cfg ? usr_pkg::ROM_CFG :
        desc_s0 ? usr_pkg::ROM_STR0 :
        desc_s1 ? usr_pkg::ROM_STR1 :
        desc_s2 ? usr_pkg::ROM_STR2 : usr_pkg::ROM_STR3;
    wire [6:0] desc_len =
        desc_dev ? usr_pkg::LEN_DEV :
        desc_cfg ? usr_pkg::LEN_CFG :
        desc_s0 ? usr_pkg::LEN_STR0 :
        desc_s1 ? usr_pkg::LEN_STR1 :
        desc_s2 ? usr_pkg::LEN_STR2 : usr_pkg::LEN_STR3;

    // Bytes of a status or configuration answer.
    wire [7:0] dev_status = {6'h00, i_remote_wake_en, i_self_powered};
    wire [7:0] ep_status = {7'h00, halt_of(idx_l, i_ep_halt)};
    wire [7:0] reg_byte0 = get_cfg ? o_config_value :
                           st_dev ? dev_status :
                           st_ep ? ep_status : 8'h00;
    wire [15:0] reg_len = get_cfg ? usr_pkg::LEN_CONFIG
                                  : usr_pkg::LEN_STATUS;
    wire [15:0] full_len = any_desc ? {9'h000, desc_len} : reg_len;
    wire [15:0] send_len = clip(full_len, w_len);

    // The halt, power and revision inputs come from logic on this clock,
    // so they are read without synchronisers.
    usr_pkg::usr_dev_state_e state;
    usr_pkg::usr_dev_state_e next_state;
    logic [15:0] pos;
    logic [15:0] len_q;
    logic [6:0] base_q;
    logic from_rom_q;
    logic [7:0] reg_q;
    logic [7:0] rom_byte;

    // A new SETUP always wins, even in the middle of a reply, because a
    // host that gives up on a transfer starts over with a fresh SETUP.
    wire take = ep.setup_valid;
    wire is_in = any_desc | any_reg;
    wire has_data = is_in && send_len != 16'h0000;
    wire sending = state == usr_pkg::DEV_SEND;
    wire [15:0] pos_inc = pos + 16'h0001;
    wire at_end = pos_inc == len_q;
    wire [6:0] rom_addr = base_q + pos[6:0];
    wire [7:0] reg_pick = pos[0] ? 8'h00 : reg_q;
    wire [7:0] next_byte = from_rom_q ? rom_byte : reg_pick;

    // Descriptor bytes are looked up one at a time as the reply runs.
    usr_desc_rom u_usr_desc_rom (
        .i_addr(rom_addr),
        .i_rev_late(i_rev_late),
        .o_byte(rom_byte)
    );

    // Reply sequencing: send the bytes, then acknowledge the status stage.
    always_comb begin
        next_state = state;
        unique case (state)
            usr_pkg::DEV_IDLE: next_state = usr_pkg::DEV_IDLE;
            usr_pkg::DEV_SEND: begin
                if (at_end)
                    next_state = usr_pkg::DEV_ACK;
            end
            usr_pkg::DEV_ACK: next_state = usr_pkg::DEV_IDLE;
            default: next_state = usr_pkg::DEV_IDLE;
        endcase
        if (take && has_data)
            next_state = usr_pkg::DEV_SEND;
        else if (take && supported)
            next_state = usr_pkg::DEV_ACK;
        else if (take)
            next_state = usr_pkg::DEV_IDLE;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            state <= usr_pkg::DEV_IDLE;
        else
            state <= next_state;
    end

    // What the reply needs is kept here, so the request bytes may change
    // once the SETUP has been taken.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            len_q <= 16'h0000;
            base_q <= 7'h00;
            from_rom_q <= 1'b0;
            reg_q <= 8'h00;
        end else if (take) begin
            len_q <= send_len;
            base_q <= desc_base;
            from_rom_q <= any_desc;
            reg_q <= reg_byte0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            pos <= 16'h0000;
        else if (take)
            pos <= 16'h0000;
        else if (sending)
            pos <= pos_inc;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ep.in_valid <= 1'b0;
            ep.in_data <= 8'h00;
            ep.in_last <= 1'b0;
        end else begin
            ep.in_valid <= sending && !take;
            ep.in_data <= next_byte;
            ep.in_last <= sending && at_end && !take;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ep.status_ack <= 1'b0;
            ep.stall <= 1'b0;
        end else begin
            ep.status_ack <= state == usr_pkg::DEV_ACK && !take;
            ep.stall <= take && !supported;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_config_value <= usr_pkg::CFG_NONE;
            o_configured <= 1'b0;
        end else if (take && set_cfg_ok) begin
            o_config_value <= val_l;
            o_configured <= val_l == usr_pkg::CFG_ONE;
        end
    end
endmodule

// ===== rtl/usr_ep0_if.sv
// Endpoint-zero link between the host controller end and the device end.
interface usr_ep0_if;
    logic setup_valid;
    logic [63:0] setup_pkt;
    logic in_valid;
    logic [7:0] in_data;
    logic in_last;
    logic status_ack;
    logic stall;
    modport dev (
        input setup_valid, setup_pkt,
        output in_valid, in_data, in_last, status_ack, stall
    );
    modport host (
        output setup_valid, setup_pkt,
        input in_valid, in_data, in_last, status_ack, stall
    );
endinterface

// ===== rtl/usr_pkg.sv
// Shared constants for the endpoint-zero standard request responder.
package usr_pkg;
    // Request type and request code values.
    localparam logic [7:0] BM_OUT_DEV = 8'h00;
    localparam logic [7:0] BM_IN_DEV = 8'h80;
    localparam logic [7:0] BM_IN_ITF = 8'h81;
    localparam logic [7:0] BM_IN_EP = 8'h82;
    localparam logic [7:0] RQ_GET_STATUS = 8'h00;
    localparam logic [7:0] RQ_GET_DESC = 8'h06;
    localparam logic [7:0] RQ_GET_CONFIG = 8'h08;
    localparam logic [7:0] RQ_SET_CONFIG = 8'h09;
    // Descriptor types carried in the high value byte.
    localparam logic [7:0] DT_DEVICE = 8'h01;
    localparam logic [7:0] DT_CONFIG = 8'h02;
    localparam logic [7:0] DT_STRING = 8'h03;
    localparam logic [15:0] LANG_ID = 16'h0409;
    localparam logic [7:0] CFG_NONE = 8'h00;
    localparam logic [7:0] CFG_ONE = 8'h01;
    // Endpoint addresses answered by get-status.
    localparam logic [7:0] EP_CTRL = 8'h00;
    localparam logic [7:0] EP_BULK_IN = 8'h81;
    localparam logic [7:0] EP_BULK_OUT = 8'h02;
    localparam logic [7:0] EP_INT_IN = 8'h83;
    // Descriptor table layout: start and length of each entry.
    localparam logic [6:0] ROM_DEV = 7'h00;
    localparam logic [6:0] LEN_DEV = 7'h12;
    localparam logic [6:0] ROM_CFG = 7'h12;
    localparam logic [6:0] LEN_CFG = 7'h27;
    localparam logic [6:0] ROM_STR0 = 7'h39;
    localparam logic [6:0] LEN_STR0 = 7'h04;
    localparam logic [6:0] ROM_STR1 = 7'h3D;
    localparam logic [6:0] LEN_STR1 = 7'h10;
    localparam logic [6:0] ROM_STR2 = 7'h4D;
    localparam logic [6:0] LEN_STR2 = 7'h1E;
    localparam logic [6:0] ROM_STR3 = 7'h6B;
    localparam logic [6:0] LEN_STR3 = 7'h0A;
    localparam int ROM_SIZE = 117;
    // Class and protocol bytes that depend on the silicon revision.
    localparam logic [6:0] ROM_ITF_CLASS = 7'h20;
    localparam logic [6:0] ROM_ITF_PROTO = 7'h22;
    localparam logic [7:0] CLASS_LATE = 8'hFF;
    localparam logic [7:0] CLASS_EARLY = 8'h00;
    localparam logic [15:0] LEN_STATUS = 16'h0002;
    localparam logic [15:0] LEN_CONFIG = 16'h0001;
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_SEND,
        DEV_ACK
    } usr_dev_state_e;
    typedef enum logic {
        HOST_IDLE,
        HOST_WAIT
    } usr_host_state_e;
endpackage

// ===== sim/usr_ep0_assertions.sv
// Concurrent checks on the endpoint-zero link between the two ends.
module usr_ep0_assertions (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_b, // Reset, active low
    input wire logic setup_valid, // Request strobe
    input wire logic [63:0] setup_pkt, // Request bytes
    input wire logic in_valid, // Reply byte valid
    input wire logic [7:0] in_data, // Reply byte
    input wire logic in_last, // Final reply byte
    input wire logic status_ack, // Status stage done
    input wire logic stall // Request refused
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    logic [15:0] cnt;
    logic [15:0] len_q;
    logic [7:0] rq_q;
    wire logic [7:0] rq = setup_pkt[15:8];
    wire logic set_cfg = setup_valid && setup_pkt[15:0] == 16'h0900
        && setup_pkt[31:16] <= 16'h0001;
    // Only the string indices and languages that are served count here.
    wire logic str_ok = setup_pkt[31:16] == 16'h0300 ||
        (setup_pkt[31:24] == 8'h03 && setup_pkt[47:32] == 16'h0409
        && setup_pkt[23:16] inside {8'h01, 8'h02, 8'h03});
    wire logic get_desc = setup_valid && setup_pkt[15:0] == 16'h0680
        && setup_pkt[63:48] != 16'h0000
        && (setup_pkt[31:24] inside {8'h01, 8'h02} || str_ok);
    // Byte count of the reply in flight, so its length can be judged.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            {cnt, len_q, rq_q} <= 40'h0;
        else if (setup_valid)
            {cnt, len_q, rq_q} <= {16'h0000, setup_pkt[63:48], rq};
        else if (in_valid)
            cnt <= cnt + 16'h0001;
    end
    sequence s_ack;
        ##[1:20] status_ack;
    endsequence
    a_cfg_acked: assert property (set_cfg |-> s_ack)
        else $error("set configuration not acknowledged");
    a_cfg_no_data: assert property (set_cfg |=> !in_valid [*4])
        else $error("set configuration produced data");
    a_desc_answered: assert property (get_desc |-> ##[1:20] in_valid)
        else $error("descriptor request not answered");
    a_desc_no_stall: assert property (get_desc |=> !stall [*8])
        else $error("descriptor request refused");
    a_odd_stalls: assert property (setup_valid && rq inside {8'h01, 8'h03,
        8'h05} |-> ##[1:20] stall)
        else $error("unsupported request not refused");
    a_within_len: assert property (in_valid |-> cnt < len_q)
        else $error("reply longer than requested");
    a_last_at_len: assert property (in_valid && cnt + 16'h0001 == len_q
        |-> in_last)
        else $error("reply runs past requested length");
    a_status_two: assert property (in_valid && in_last && rq_q == 8'h00
        |-> cnt == 16'h0001)
        else $error("status reply is not two bytes");
    a_config_one: assert property (in_valid && in_last && rq_q == 8'h08
        |-> cnt == 16'h0000)
        else $error("configuration reply is not one byte");
    a_config_value: assert property (in_valid && rq_q == 8'h08
        |-> in_data <= 8'h01)
        else $error("configuration reply holds an unknown value");
endmodule

// ===== sim/usr_standard_request_responder_tb.sv
// Bench that plays the host on endpoint zero and checks every reply.
module usr_standard_request_responder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic rev = 1'b1;
    logic [3:0] halt = 4'h4;
    logic o_configured;
    logic [7:0] o_config_value;
    logic [319:0] got;
    int failures = 0;
    int num_checks = 0;
    usr_ep0_if ep ();
    usr_dev_end u_usr_dev_end (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .ep(ep.dev), .i_rev_late(rev), .i_ep_halt(halt),
        .i_self_powered(1'b1), .i_remote_wake_en(1'b0),
        .o_configured(o_configured), .o_config_value(o_config_value));
    usr_ep0_assertions u_usr_ep0_assertions (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .setup_valid(ep.setup_valid),
        .setup_pkt(ep.setup_pkt), .in_valid(ep.in_valid),
        .in_data(ep.in_data), .in_last(ep.in_last),
        .status_ack(ep.status_ack), .stall(ep.stall));
    always #20 i_sys_clk = ~i_sys_clk;
    task automatic check(input logic [319:0] seen, input logic [319:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Mode 0 gathers a reply with its byte count on top, 1 awaits the
    // status acknowledge and 2 awaits a stall.
    task automatic xfer(input logic [63:0] pkt, input int mode);
        got = '0;
        num_checks += int'(mode != 0);
        @(posedge i_sys_clk) #1;
        ep.setup_valid = 1'b1;
        ep.setup_pkt = pkt;
        @(posedge i_sys_clk) #1;
        ep.setup_valid = 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(negedge i_sys_clk);
            if (mode == 1 && ep.status_ack === 1'b1)
                return;
            if (mode == 2 && ep.stall === 1'b1)
                return;
            if (mode == 0 && ep.in_valid === 1'b1) begin
                got = {got[319:312] + 8'h01, got[303:0], ep.in_data};
                if (ep.in_last === 1'b1)
                    return;
            end
        end
        failures++;
        $display("unexpected hang at %0t: got %h want %h", $time, got, pkt);
        complete_run();
    endtask
    task automatic t_config();
        for (int v = 1; v >= 0; v--) begin
            xfer({32'h0, 16'(v), 16'h0900}, 1);
            check(320'({o_configured, o_config_value}), 320'(v * 257));
            xfer(64'h0001_0000_0000_0880, 0);
            check(got, {8'h01, 312'(v)});
        end
    endtask
    task automatic t_desc();
        xfer(64'h0012_0000_0100_0680, 0);
        check(got, {8'h12, 168'h0,
            144'h120110010000000834127856000201020301});
        xfer(64'h0005_0000_0100_0680, 0);
        check(got, {8'h05, 312'h1201100100});
        xfer(64'h00FF_0000_0200_0680, 0);
        check(got, {8'h27, 152'h09022700010100A0500904000003FF00FF0007,
            160'h0581024000000705020240000007058303080001});
        @(posedge i_sys_clk) #1 rev = 1'b0;
        xfer(64'h0011_0000_0200_0680, 0);
        check(got, {8'h11, 312'h09022700010100A0500904000003000000});
        @(posedge i_sys_clk) #1 rev = 1'b1;
    endtask
    task automatic t_strings();
        xfer(64'h00FF_0000_0300_0680, 0);
        check(got, {8'h04, 312'h04030409});
        xfer(64'h00FF_0409_0301_0680, 0);
        check(320'({got[319:312], got[127:112]}), 320'h101003);
        xfer(64'h0002_0409_0301_0680, 0);
        check(got, {8'h02, 312'h1003});
        xfer(64'h00FF_0409_0302_0680, 0);
        check(got, {8'h1E, 72'h0, 120'h1E035500530042002000310030002F,
            120'h0031003000300020004C0041004E00});
        xfer(64'h00FF_0409_0303_0680, 0);
        check(got, {8'h0A, 312'h0A033000300030003100});
    endtask
    task automatic t_status();
        logic [7:0] eps [4] = '{8'h00, 8'h81, 8'h02, 8'h83};
        xfer(64'h0002_0000_0000_0080, 0);
        check(got, {8'h02, 312'h0100});
        xfer(64'h0002_0000_0000_0081, 0);
        check(got, {8'h02, 312'h0000});
        foreach (eps[i]) begin
            xfer({16'h0002, 8'h00, eps[i], 32'h0000_0082}, 0);
            check(got, {8'h02, 303'h0, halt[i], 8'h00});
        end
        xfer(64'h0000_0000_0005_0500, 2);
        xfer(64'h0001_0000_0000_05C0, 2);
    endtask
    initial begin
        ep.setup_valid = 1'b0;
        ep.setup_pkt = 64'h0;
        repeat (6) @(posedge i_sys_clk);
        #1 i_rst_b = 1'b1;
        t_config();
        t_desc();
        t_strings();
        t_status();
        complete_run();
    end
endmodule
